// ---- core/blit_engine_status.sv ----
`timescale 1ns/1ps
`default_nettype none

// Function
// - Status bit 2 shows queued transfer
// - Parameter writes while pending change queued op
// - Status bit 1 shows pipeline processing
// - Status bit 0 shows transfer in progress
// - Transfer flag holds until memory drains
// - VGA emulation base register at 8210h
module blit_engine_status
    import blit_status_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Memory controller side
    output logic             mem_req,
    output logic      [31:0] mem_addr,
    input  wire logic        mem_done,
    // VGA emulation
    output logic      [31:0] vga_base,
    // Interrupt
    output logic             irq
);

    // Bus decode
    logic        access;      // Access phase with answer this edge
    logic        wr_en;       // Write takes effect
    logic        rd_en;       // Read data captured
    logic        addr_hit;    // Address maps to a register
    logic [31:0] rd_value;    // Read mux output

    // Software visible parameter set; source and count copied at launch, destination never used
    logic [31:0]            src_param;   // Source address
    logic [31:0]            dst_param;   // Destination address
    logic [COUNT_WIDTH-1:0] count_param; // Number of memory requests

    // Working copy of the running operation
    logic [COUNT_WIDTH-1:0] remaining;   // Requests left to issue
    logic [31:0]            run_addr;    // Next request address
    pipe_state_t            state;       // Sequencer state

    // Queue and status
    logic                   pending;     // Second op waiting
    logic                   xfer_active; // Live transfer busy
    logic                   xfer_prev;   // Previous transfer busy
    logic [STAT_WIDTH-1:0]  status_word; // Engine status value

    // Launch control
    logic                   start_req;     // Software start command
    logic                   finishing;     // Last cycle of an op
    logic                   launch_queued; // Queued op begins
    logic                   launch_direct; // Start begins at once
    logic                   queue_start;   // Start must wait

    // Interrupt state
    logic [INT_WIDTH-1:0]   int_status;  // Sticky events
    logic [INT_WIDTH-1:0]   int_mask;    // Enables
    logic [INT_WIDTH-1:0]   int_events;  // Events this cycle

    // Tracker link
    mem_track_if trk ();

    mem_request_tracker u_tracker (
        .pclk    (pclk),
        .presetn (presetn),
        .trk     (trk)
    );

    // Answer comes one cycle into the access phase
    assign access = psel && penable && pready;
    // Writes land on the edge that completes the access
    assign wr_en  = access && pwrite && addr_hit;
    // Read data loads one edge early, so that it
    // already stands while pready is high
    assign rd_en  = psel && penable && !pready && !pwrite;

    // Address decode for mapped registers
    // Unmapped places fall to the default and raise pslverr
    always_comb begin
        case (paddr)
            ADDR_SRC_PARAM,
            ADDR_DST_PARAM,
            ADDR_COUNT_PARAM,
            ADDR_COMMAND,
            ADDR_ENG_STATUS,
            ADDR_VGA_BASE,
            ADDR_INT_STATUS,
            ADDR_INT_MASK: addr_hit = 1'b1;
            default:       addr_hit = 1'b0;
        endcase
    end

    // Ready pulses once per access, giving one wait state
    // Fixed timing keeps the master simple; no back-pressure
    // Cleared again on the edge after it was seen high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // Error flag rides with ready for unmapped addresses
    // Decoded in the wait cycle, where paddr already stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && penable && !pready && !addr_hit;
        end
    end

    // Engine status assembly
    // Flags are live levels, nothing is captured for a read
    always_comb begin
        status_word = '0;
        status_word[STAT_XFER_ACTIVE_BIT]  = xfer_active;
        status_word[STAT_PIPE_ACTIVE_BIT]  = (state == PIPE_RUN);
        status_word[STAT_XFER_PENDING_BIT] = pending;
    end

    // Read multiplexer; command reads back as zero
    // Unmapped places read as zero as well
    // Count is sixteen bits wide, its upper half reads zero
    always_comb begin
        case (paddr)
            ADDR_SRC_PARAM:   rd_value = src_param;
            ADDR_DST_PARAM:   rd_value = dst_param;
            ADDR_COUNT_PARAM: rd_value = {16'h0000, count_param};
            ADDR_ENG_STATUS:  rd_value = {24'h00_0000, status_word};
            ADDR_VGA_BASE:    rd_value = vga_base;
            ADDR_INT_STATUS:  rd_value = {29'h0000_0000, int_status};
            ADDR_INT_MASK:    rd_value = {29'h0000_0000, int_mask};
            default:          rd_value = RESET_WORD;
        endcase
    end

    // Read data held between accesses
    // Holding the last value keeps the bus from toggling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RESET_WORD;
        end else if (rd_en) begin
            prdata <= rd_value;
        end
    end

    // Parameter registers; no lock against busy engine
    // Software must not write here while a start is queued,
    // or the queued op runs with the new values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_param   <= RESET_WORD;
            dst_param   <= RESET_WORD;
            count_param <= RESET_COUNT;
        end else if (wr_en) begin
            case (paddr)
                ADDR_SRC_PARAM:   src_param   <= pwdata;
                ADDR_DST_PARAM:   dst_param   <= pwdata;
                ADDR_COUNT_PARAM: count_param <= pwdata[COUNT_WIDTH-1:0];
                default:          ;
            endcase
        end
    end

    // VGA emulation base, plain storage for the emulation logic
    // Its contents have no meaning inside this block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vga_base <= RESET_WORD;
        end else if (wr_en && paddr == ADDR_VGA_BASE) begin
            vga_base <= pwdata;
        end
    end

    // Start command decode
    // Other command bits are ignored
    assign start_req = wr_en && paddr == ADDR_COMMAND
                       && pwdata[CMD_START_BIT];

    // Last run cycle: nothing left to issue
    // A zero count still spends this one cycle in RUN
    assign finishing = (state == PIPE_RUN) && (remaining == RESET_COUNT);

    // Queued op takes over when the running one ends
    assign launch_queued = finishing && pending;

    // Start runs at once if the pipe is free or frees now
    assign launch_direct = start_req
                           && ((state == PIPE_IDLE)
                               || (finishing && !pending));

    // Otherwise the start waits in the single queue slot
    assign queue_start = start_req && !launch_direct;

    // Queue flag; a new start beats the consuming launch
    // Only one slot: a start while pending is lost, so
    // software has to poll the flag before starting again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
        end else if (queue_start) begin
            pending <= 1'b1;
        end else if (launch_queued) begin
            pending <= 1'b0;
        end
    end

    // Sequencer state
    // Back-to-back ops stay in RUN with no idle gap,
    // so the pipe flag never dips between them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PIPE_IDLE;
        end else begin
            case (state)
                PIPE_IDLE: begin
                    if (launch_direct) begin
                        state <= PIPE_RUN;
                    end
                end
                PIPE_RUN: begin
                    if (finishing && !launch_queued && !launch_direct) begin
                        state <= PIPE_IDLE;
                    end
                end
                default: state <= PIPE_IDLE;
            endcase
        end
    end

    // Working copy; parameters latched only at launch
    // Later parameter writes cannot disturb a running op
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remaining <= RESET_COUNT;
            run_addr  <= RESET_WORD;
        end else if (launch_direct || launch_queued) begin
            // queued op picks up latest values
            remaining <= count_param;
            run_addr  <= src_param;
        end else if (state == PIPE_RUN && remaining != RESET_COUNT) begin
            remaining <= remaining - 16'h0001;
            run_addr  <= run_addr + ADDR_STEP;
        end
    end

    // One request per run cycle while work remains
    assign trk.issue = (state == PIPE_RUN) && (remaining != RESET_COUNT);
    assign trk.done  = mem_done;

    // Request outputs registered toward the memory controller
    // Address is launched together with its request pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req  <= 1'b0;
            mem_addr <= RESET_WORD;
        end else begin
            mem_req  <= trk.issue;
            mem_addr <= run_addr;
        end
    end

    // Pipe, tracker and the last request together cover
    // every cycle until the memory side has gone quiet
    // busy until memory drains
    assign xfer_active = (state == PIPE_RUN) || !trk.idle || mem_req;

    // Previous busy level for completion edge
    // Resets low like the transfer flag, so no false done event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_prev <= 1'b0;
        end else begin
            xfer_prev <= xfer_active;
        end
    end

    // Event sources for the interrupt status
    // Each is a single-cycle pulse
    always_comb begin
        int_events = '0;
        int_events[INT_XFER_DONE_BIT]   = xfer_prev && !xfer_active;
        int_events[INT_PIPE_IDLE_BIT]   = finishing && !launch_queued
                                          && !launch_direct;
        int_events[INT_QUEUE_START_BIT] = launch_queued;
    end

    // Sticky status, write one to clear; new event wins
    // An event in the cycle of its clear is not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= RESET_INT;
        end else if (wr_en && paddr == ADDR_INT_STATUS) begin
            int_status <= (int_status & ~pwdata[INT_WIDTH-1:0])
                          | int_events;
        end else begin
            int_status <= int_status | int_events;
        end
    end

    // Interrupt enables
    // Masking hides a bit from irq but leaves it sticky
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= RESET_INT;
        end else if (wr_en && paddr == ADDR_INT_MASK) begin
            int_mask <= pwdata[INT_WIDTH-1:0];
        end
    end

    // Level interrupt, one cycle behind status
    // Registered so that the pin is free of glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end

endmodule
`default_nettype wire

// ---- core/blit_status_pkg.sv ----
// Shared constants for the transfer engine status block
package blit_status_pkg;

    // Register byte addresses inside the device register area
    localparam logic [15:0] ADDR_SRC_PARAM   = 16'h8100;
    localparam logic [15:0] ADDR_DST_PARAM   = 16'h8104;
    localparam logic [15:0] ADDR_COUNT_PARAM = 16'h8108;
    localparam logic [15:0] ADDR_COMMAND     = 16'h810C;
    localparam logic [15:0] ADDR_ENG_STATUS  = 16'h820C;
    localparam logic [15:0] ADDR_VGA_BASE    = 16'h8210;
    localparam logic [15:0] ADDR_INT_STATUS  = 16'h8300;
    localparam logic [15:0] ADDR_INT_MASK    = 16'h8304;

    // Engine status field positions
    localparam int STAT_XFER_ACTIVE_BIT  = 0;
    localparam int STAT_PIPE_ACTIVE_BIT  = 1;
    localparam int STAT_XFER_PENDING_BIT = 2;
    localparam int STAT_WIDTH            = 8;

    // Command field positions
    localparam int CMD_START_BIT = 0;

    // Interrupt field positions and width
    localparam int INT_XFER_DONE_BIT   = 0;
    localparam int INT_PIPE_IDLE_BIT   = 1;
    localparam int INT_QUEUE_START_BIT = 2;
    localparam int INT_WIDTH           = 3;

    // Widths of datapath fields
    localparam int COUNT_WIDTH = 16;
    localparam int OUTST_WIDTH = 8;

    // Reset values
    localparam logic [31:0]            RESET_WORD  = 32'h0000_0000;
    localparam logic [COUNT_WIDTH-1:0] RESET_COUNT = 16'h0000;
    localparam logic [INT_WIDTH-1:0]   RESET_INT   = 3'h0;
    localparam logic [OUTST_WIDTH-1:0] RESET_OUTST = 8'h00;

    // Address step between successive memory requests
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

    // Pipeline sequencer states
    typedef enum logic [0:0] {
        PIPE_IDLE = 1'b0,
        PIPE_RUN  = 1'b1
    } pipe_state_t;

endpackage

// ---- core/mem_track_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Link between the sequencer and the outstanding request tracker
interface mem_track_if;
    import blit_status_pkg::*;
    logic                   issue;       // Request sent this cycle
    logic                   done;        // Memory finished one request
    logic                   idle;        // Nothing outstanding
    logic [OUTST_WIDTH-1:0] outstanding; // Requests in flight

    modport engine  (output issue, output done, input idle,
                     input outstanding);
    modport tracker (input issue, input done, output idle,
                     output outstanding);
endinterface
`default_nettype wire

// ---- core/mem_request_tracker.sv ----
`timescale 1ns/1ps
`default_nettype none
// Counts memory requests issued but not yet handled
module mem_request_tracker
    import blit_status_pkg::*;
(
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Sequencer side
    mem_track_if.tracker trk
);

    logic [OUTST_WIDTH-1:0] count; // Requests in flight

    // Issue and completion in one cycle cancel out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= RESET_OUTST;
        end else if (trk.issue && !trk.done) begin
            count <= count + 8'h01;
        end else if (!trk.issue && trk.done && count != RESET_OUTST) begin
            // Stray completions are dropped to avoid underflow
            count <= count - 8'h01;
        end
    end

    assign trk.outstanding = count;
    assign trk.idle        = (count == RESET_OUTST);

endmodule
`default_nettype wire

// ---- verif/blit_engine_status_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks of the status block
module blit_status_sva
    import blit_status_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Memory side and outputs
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_done,
    input wire logic [31:0] vga_base,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access completing at this edge
    wire logic fin  = psel && penable && pready;
    // Status read completing, data stands with pready
    wire logic stat = fin && !pwrite && paddr == ADDR_ENG_STATUS;
    a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_reserved_zero: assert property (stat |-> prdata[31:3] == 29'h0)
        else $error("reserved status bits not zero");
    a_vga_write: assert property (
        fin && pwrite && paddr == ADDR_VGA_BASE
        |=> vga_base == $past(pwdata))
        else $error("vga base not loaded");
    a_vga_read: assert property (
        fin && !pwrite && paddr == ADDR_VGA_BASE |-> prdata == vga_base)
        else $error("vga base read mismatch");
    a_busy_on_req: assert property (
        stat && $past(mem_req) |-> prdata[STAT_XFER_ACTIVE_BIT])
        else $error("transfer flag low during request");
    // Main scenarios reached
    c_busy_read: cover property (stat && mem_req);
    c_refused: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule
bind blit_engine_status blit_status_sva chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_done(mem_done),
    .vga_base(vga_base), .irq(irq));
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the status block
module testbench;
    import blit_status_pkg::*;
    // Driven inputs
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [15:0] paddr    = 16'h0000;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic        mem_done = 1'b0;
    // Observed outputs
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mem_req;
    logic [31:0] mem_addr;
    logic [31:0] vga_base;
    logic        irq;
    // Bench state
    int          seed        = 32'h71C98195;
    int          bad_count   = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    int          owed        = 0;
    int          gap         = 0;
    logic [31:0] rd;
    logic        err;
    logic [31:0] exp_addr[$];

    blit_engine_status uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_done(mem_done),
        .vga_base(vga_base), .irq(irq));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    task automatic chk(input string n, input logic [31:0] g,
                       input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Expected engine status word from the three flags
    function automatic logic [31:0] stat_word(input logic x, input logic p,
                                              input logic q);
        stat_word                        = 32'h0000_0000;
        stat_word[STAT_XFER_ACTIVE_BIT]  = x;
        stat_word[STAT_PIPE_ACTIVE_BIT]  = p;
        stat_word[STAT_XFER_PENDING_BIT] = q;
    endfunction

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; waits for pready however long it takes
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        // Response and read data taken at the completing edge
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Poll status until masked bits match
    task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
        do apb(1'b0, ADDR_ENG_STATUS, 32'h0); while ((rd & m) !== v);
    endtask

    // Slow memory: one answer per four cycles, so requests pile up
    always @(posedge pclk) begin
        gap = (gap + 1) % 4;
        if (mem_req === 1'b1) begin
            owed = owed + 1;
            chk("mem_addr", mem_addr, exp_addr.size() ? exp_addr.pop_front()
                : 32'hDEAD_0000);
        end
        if (owed > 0 && gap == 0) begin
            owed = owed - 1;
            mem_done <= 1'b1;
        end else begin
            mem_done <= 1'b0;
        end
    end

    // Hang guard, well above the expected run length
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        logic [31:0] v;
        logic [31:0] s1;
        logic [31:0] s2;
        int          n1;
        int          n2;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Idle flags, read-only status ignores writes
        apb(1'b1, ADDR_ENG_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_ENG_STATUS, 32'h0);
        chk("idle_stat", rd, stat_word(1'b0, 1'b0, 1'b0));
        apb(1'b0, ADDR_VGA_BASE, 32'h0);
        chk("vga_reset", rd, 32'h0);
        // Random words through the VGA base
        repeat (4) begin
            v = $random(seed);
            apb(1'b1, ADDR_VGA_BASE, v);
            apb(1'b0, ADDR_VGA_BASE, 32'h0);
            chk("vga_rd", rd, v);
            chk("vga_pin", vga_base, v);
            apb(1'b1, ADDR_DST_PARAM, ~v);
            apb(1'b0, ADDR_DST_PARAM, 32'h0);
            chk("dst_rd", rd, ~v);
        end
        // Unmapped place is refused and reads zero
        apb(1'b1, 16'h8400, 32'hFFFF_FFFF);
        chk("err_wr", {31'h0, err}, 32'h1);
        apb(1'b0, 16'h8400, 32'h0);
        chk("err_rd", {err, rd[30:0]}, 32'h8000_0000);
        // Long op, then a queued one with reloaded parameters
        s1 = $random(seed) & 32'hFFFF_FFFC;
        s2 = $random(seed) & 32'hFFFF_FFFC;
        n1 = 40 + ($random(seed) & 15);
        n2 = 1 + ($random(seed) & 7);
        for (int i = 0; i < n1; i++) exp_addr.push_back(s1 + 32'(4 * i));
        for (int i = 0; i < n2; i++) exp_addr.push_back(s2 + 32'(4 * i));
        apb(1'b1, ADDR_INT_MASK, 32'h1);
        apb(1'b1, ADDR_SRC_PARAM, s1);
        apb(1'b1, ADDR_COUNT_PARAM, 32'(n1));
        apb(1'b1, ADDR_COMMAND, 32'h1);
        apb(1'b1, ADDR_COMMAND, 32'h1);
        apb(1'b0, ADDR_ENG_STATUS, 32'h0);
        chk("queued", rd, stat_word(1'b1, 1'b1, 1'b1));
        apb(1'b1, ADDR_SRC_PARAM, s2);
        apb(1'b1, ADDR_COUNT_PARAM, 32'(n2));
        // Third start while queued must be dropped
        apb(1'b1, ADDR_COMMAND, 32'h1);
        wait_stat(32'h6, 32'h0);
        chk("draining", rd, stat_word(1'b1, 1'b0, 1'b0));
        wait_stat(32'hFF, 32'h0);
        chk("left", 32'(exp_addr.size()), 32'h0);
        // Events, mask and write-one-to-clear
        apb(1'b0, ADDR_INT_STATUS, 32'h0);
        chk("int_all", rd, 32'h7);
        chk("irq_on", {31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_INT_STATUS, 32'h1);
        apb(1'b0, ADDR_INT_STATUS, 32'h0);
        chk("int_left", rd, 32'h6);
        chk("irq_off", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_INT_MASK, 32'h6);
        apb(1'b0, ADDR_INT_MASK, 32'h0);
        chk("irq_mask", {irq, rd[30:0]}, 32'h8000_0006);
        apb(1'b1, ADDR_INT_STATUS, 32'h7);
        apb(1'b0, ADDR_INT_STATUS, 32'h0);
        chk("int_clr", {irq, rd[30:0]}, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
